//--- core/tsc_pkg.sv
package tsc_pkg;
   // status word bit positions
   localparam int unsigned STS_W        = 16;
   localparam int unsigned BIT_MBAD     = 3;
   localparam int unsigned BIT_RSVD     = 4;
   localparam int unsigned BIT_LATE     = 5;
   localparam int unsigned BIT_XCOL     = 6;
   // collision limit and slot time
   localparam logic [4:0]  COLL_LIMIT   = 5'h10;
   localparam int unsigned CLK_NS       = 10;
   localparam int unsigned SLOT_NS      = 51200;   // 51.2 us
   localparam int unsigned SLOT_CYC     = SLOT_NS / CLK_NS;
   localparam int unsigned CNT_W        = 13;
   localparam int unsigned FIFO_DEPTH   = 16;
   localparam logic [15:0] STS_RESET    = 16'h0000;

   // one finished packet's status, as written back to the descriptor
   typedef struct packed {
      logic [15:0] status;
      logic        aborted;
   } tsc_result_t;

   // line events from the transmit/receive units
   typedef struct packed {
      logic pkt_start;    // first preamble bit
      logic sfd_seen;     // start-of-frame delimiter sent
      logic collision;    // collision detected on the wire
      logic pkt_end;      // transmission attempt over (no collision)
      logic mon_done;     // receive monitor finished the packet
      logic mon_crc_bad;  // monitor computed invalid crc
   } tsc_evt_t;
endpackage

//--- core/tsc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module tsc_fifo #(
   parameter int unsigned W = 17,
   parameter int unsigned D = 16
) (
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rstn,
   // write side
   input  wire logic [W-1:0] in_data,
   input  wire logic         in_valid,
   output logic              in_ready,
   // read side
   output logic [W-1:0]      out_data,
   output logic              out_valid,
   input  wire logic         out_ready
);
   localparam int unsigned AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW:0]  wr_ff;
   logic [AW:0]  rd_ff;
   logic         do_wr;
   logic         do_rd;

   // full when pointers differ only in the wrap bit
   assign in_ready  = (wr_ff ^ rd_ff) != {1'b1, {AW{1'b0}}};
   assign out_valid = wr_ff != rd_ff;
   assign out_data  = mem[rd_ff[AW-1:0]];
   assign do_wr     = in_valid && in_ready;
   assign do_rd     = out_valid && out_ready;

   // storage has no reset, only the pointers do
   always_ff @(posedge clk_sys) begin
      if (do_wr) begin
         mem[wr_ff[AW-1:0]] <= in_data;
      end
   end

   // pointers
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wr_ff <= '0;
         rd_ff <= '0;
      end else begin
         if (do_wr) begin
            wr_ff <= wr_ff + 1'b1;
         end
         if (do_rd) begin
            rd_ff <= rd_ff + 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

//--- core/tsc_status.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - sixteen collisions on one packet abort it and set status bit 6
// - collision after 51.2 us slot from reference sets status bit 5
// - window starts at first preamble bit or at delimiter, by select bit
// - late collision does not abort; normal backoff and retry follow
// - late flag cleared per packet, reflects only that packet
// - monitor computing bad crc on own packet sets status bit 3
module tsc_status
   import tsc_pkg::*;
(
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   // configuration
   input  wire logic        late_collision_reference_select,
   // line events (asynchronous to clk_sys)
   input  wire tsc_evt_t    evt_in,
   // collision handling toward the transmit unit
   output logic             backoff_req,
   output logic             abort_req,
   // descriptor status write-back stream
   output logic [15:0]      sts_data,
   output logic             sts_valid,
   input  wire logic        sts_ready,
   output logic             sts_aborted,
   // status view
   output logic             excessive_collision_flag,
   output logic             late_collision_flag,
   output logic             monitored_bad_flag,
   output logic             stall
);
   tsc_evt_t     sync1_ff;
   tsc_evt_t     sync2_ff;
   tsc_evt_t     prev_ff;
   tsc_evt_t     ev;
   logic [4:0]   coll_cnt_ff;
   logic [CNT_W-1:0] win_cnt_ff;
   logic         win_run_ff;
   logic         xcol_ff;
   logic         late_ff;
   logic         mbad_ff;
   logic         backoff_ff;
   logic         abort_ff;
   logic         push_ff;
   tsc_result_t  push_data_ff;
   logic         in_ready;
   logic         q_valid;
   tsc_result_t  q_data;
   logic         out_valid_ff;
   tsc_result_t  out_data_ff;
   logic         q_pop;
   logic         slot_over;
   logic         done_pkt;

   typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_MON} tsc_state_t;
   tsc_state_t   st_ff;

   // two-flop synchroniser, then rising-edge detect on the second stage
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
         prev_ff  <= '0;
      end else begin
         sync1_ff <= evt_in;
         sync2_ff <= sync1_ff;
         prev_ff  <= sync2_ff;
      end
   end
   assign ev        = sync2_ff & ~prev_ff;
   assign slot_over = win_cnt_ff >= CNT_W'(SLOT_CYC);

   // slot window counter; reference chosen by the select bit
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         win_cnt_ff <= '0;
         win_run_ff <= 1'b0;
      end else if (ev.collision || ev.pkt_end) begin
         win_run_ff <= 1'b0;
      end else if (late_collision_reference_select ? ev.sfd_seen
                                                   : ev.pkt_start) begin
         win_cnt_ff <= '0;
         win_run_ff <= 1'b1;
      end else if (win_run_ff && !slot_over) begin
         win_cnt_ff <= win_cnt_ff + 1'b1;
      end
   end

   // packet sequencing and collision counting
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         st_ff       <= ST_IDLE;
         coll_cnt_ff <= '0;
         xcol_ff     <= 1'b0;
         late_ff     <= 1'b0;
         mbad_ff     <= 1'b0;
         backoff_ff  <= 1'b0;
         abort_ff    <= 1'b0;
      end else begin
         backoff_ff <= 1'b0;
         abort_ff   <= 1'b0;
         case (st_ff)
            ST_IDLE: begin
               if (ev.pkt_start && in_ready) begin
                  st_ff       <= ST_SEND;
                  coll_cnt_ff <= '0;
                  xcol_ff     <= 1'b0;
                  late_ff     <= 1'b0;
                  mbad_ff     <= 1'b0;
               end
            end
            ST_SEND: begin
               if (ev.collision) begin
                  if (win_run_ff && slot_over) begin
                     late_ff <= 1'b1;
                  end
                  if (coll_cnt_ff == COLL_LIMIT - 5'h01) begin
                     xcol_ff  <= 1'b1;
                     abort_ff <= 1'b1;
                     st_ff    <= ST_IDLE;
                  end else begin
                     coll_cnt_ff <= coll_cnt_ff + 5'h01;
                     backoff_ff  <= 1'b1;
                  end
               end else if (ev.pkt_end) begin
                  st_ff <= ST_MON;
               end
            end
            ST_MON: begin
               if (ev.mon_done) begin
                  mbad_ff <= ev.mon_crc_bad | sync2_ff.mon_crc_bad;
                  st_ff   <= ST_IDLE;
               end
            end
            default: st_ff <= ST_IDLE;
         endcase
      end
   end

   assign done_pkt = (st_ff == ST_MON && ev.mon_done) || abort_ff;

   // build the status word once the packet is finished
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         push_ff      <= 1'b0;
         push_data_ff <= '0;
      end else begin
         push_ff <= done_pkt && !abort_ff || abort_ff;
         push_data_ff.status            <= STS_RESET;
         push_data_ff.status[BIT_XCOL]  <= xcol_ff | abort_ff;
         push_data_ff.status[BIT_LATE]  <= late_ff;
         push_data_ff.status[BIT_MBAD]  <= (st_ff == ST_MON) &&
            ev.mon_done && (ev.mon_crc_bad | sync2_ff.mon_crc_bad);
         push_data_ff.status[BIT_RSVD]  <= 1'b0;
         push_data_ff.aborted           <= abort_ff;
      end
   end

   // queue so descriptor write-back latency does not lose results
   tsc_fifo #(.W($bits(tsc_result_t)), .D(FIFO_DEPTH)) u_fifo (
      .clk_sys   (clk_sys),
      .rstn      (rstn),
      .in_data   (push_data_ff),
      .in_valid  (push_ff),
      .in_ready  (in_ready),
      .out_data  (q_data),
      .out_valid (q_valid),
      .out_ready (q_pop)
   );
   assign q_pop = q_valid && (!out_valid_ff || sts_ready);

   // registered output stage
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         out_valid_ff <= 1'b0;
         out_data_ff  <= '0;
      end else if (q_pop) begin
         out_valid_ff <= 1'b1;
         out_data_ff  <= q_data;
      end else if (sts_ready) begin
         out_valid_ff <= 1'b0;
      end
   end

   // flag outputs and stall, all registered
   logic stall_ff;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         stall_ff <= 1'b0;
      end else begin
         stall_ff <= !in_ready;
      end
   end

   assign sts_valid                = out_valid_ff;
   assign sts_data                 = out_data_ff.status;
   assign sts_aborted              = out_data_ff.aborted;
   assign backoff_req              = backoff_ff;
   assign abort_req                = abort_ff;
   assign excessive_collision_flag = xcol_ff;
   assign late_collision_flag      = late_ff;
   assign monitored_bad_flag       = mbad_ff;
   assign stall                    = stall_ff;

   // assertions
   a_xcol_abort: assert property (@(posedge clk_sys)
      disable iff (!rstn) abort_req |-> excessive_collision_flag)
      else $error("abort without excessive flag");
   a_xcol_count: assert property (@(posedge clk_sys)
      disable iff (!rstn)
      (st_ff == ST_SEND && ev.collision && coll_cnt_ff == 5'h0f)
      |=> abort_req && !backoff_req)
      else $error("sixteenth collision did not abort");
   a_late_set: assert property (@(posedge clk_sys)
      disable iff (!rstn)
      (st_ff == ST_SEND && ev.collision && win_run_ff && slot_over)
      |=> late_collision_flag)
      else $error("late collision not flagged");
   a_late_early: assert property (@(posedge clk_sys)
      disable iff (!rstn)
      (st_ff == ST_SEND && ev.collision && !late_collision_flag &&
       !(win_run_ff && slot_over)) |=> !late_collision_flag)
      else $error("early collision flagged late");
   a_ref_restart: assert property (@(posedge clk_sys)
      disable iff (!rstn)
      (!ev.collision && !ev.pkt_end && late_collision_reference_select &&
       ev.sfd_seen) |=> win_cnt_ff == '0)
      else $error("window not restarted at delimiter");
   a_ref_preamble: assert property (@(posedge clk_sys)
      disable iff (!rstn)
      (!ev.collision && !ev.pkt_end && !late_collision_reference_select &&
       ev.pkt_start) |=> win_run_ff && win_cnt_ff == '0)
      else $error("window not restarted at preamble");
   a_late_retry: assert property (@(posedge clk_sys)
      disable iff (!rstn)
      (st_ff == ST_SEND && ev.collision && coll_cnt_ff < 5'h0f)
      |=> backoff_req && !abort_req)
      else $error("collision below limit did not back off");
   a_late_clear: assert property (@(posedge clk_sys)
      disable iff (!rstn)
      (st_ff == ST_IDLE && ev.pkt_start && in_ready)
      |=> !late_collision_flag)
      else $error("late flag kept across packets");
   a_mbad_word: assert property (@(posedge clk_sys)
      disable iff (!rstn)
      (st_ff == ST_MON && ev.mon_done && sync2_ff.mon_crc_bad)
      |=> push_ff && push_data_ff.status[BIT_MBAD])
      else $error("bad crc not reported");
   a_rsvd_zero: assert property (@(posedge clk_sys)
      disable iff (!rstn) sts_valid |-> !sts_data[BIT_RSVD])
      else $error("reserved status bit set");
   c_abort:   cover property (@(posedge clk_sys) disable iff (!rstn)
      abort_req);
   c_late:    cover property (@(posedge clk_sys) disable iff (!rstn)
      sts_valid && sts_ready && sts_data[BIT_LATE]);
   c_mbad:    cover property (@(posedge clk_sys) disable iff (!rstn)
      sts_valid && sts_ready && sts_data[BIT_MBAD]);
   c_full:    cover property (@(posedge clk_sys) disable iff (!rstn)
      !in_ready);
endmodule
`default_nettype wire

//--- dv/tsc_medium_model.sv
`timescale 1ns/1ps
`default_nettype none
// line side: every event is a level that rises once, then falls back
module tsc_medium_model
   import tsc_pkg::*;
(
   // clock
   input  wire logic clk_sys,
   // line events toward the status block
   output var tsc_evt_t evt_out
);
   // lines rest low between events
   initial evt_out = '0;

   // four cycles high, four low: the sync and edge detect need spacing
   task automatic pulse(input int idx);
      evt_out[idx] = 1'b1;
      repeat (4) @(negedge clk_sys);
      evt_out[idx] = 1'b0;
      repeat (4) @(negedge clk_sys);
   endtask

   // whole packet: start, delimiter, end, then the monitor verdict
   task automatic frame(input bit bad);
      pulse(5);
      pulse(4);
      pulse(2);
      evt_out.mon_crc_bad = bad;  // must stand before the monitor edge
      pulse(1);
      evt_out.mon_crc_bad = 1'b0;
   endtask
endmodule
`default_nettype wire

//--- dv/tx_status_collision_flags_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) begin samples_checked++; if ((act) !== (exp)) begin \
   n_fail++; $display("FAIL t=%0t got %h expected %h", $time, act, exp); \
   end end
module tx_status_collision_flags_tb_top
   import tsc_pkg::*;
   ;
   logic        clk_sys;
   logic        rstn;
   logic        late_collision_reference_select;
   logic        sts_ready;
   tsc_evt_t    evt;
   logic        backoff_req;
   logic        abort_req;
   logic [15:0] sts_data;
   logic        sts_valid;
   logic        sts_aborted;
   logic        excessive_collision_flag;
   logic        late_collision_flag;
   logic        monitored_bad_flag;
   logic        stall;
   int          n_fail = 0;
   int          samples_checked = 0;
   int          n_backoff = 0;
   int          n_abort = 0;

   tsc_medium_model med (.clk_sys(clk_sys), .evt_out(evt));
   tsc_status uut (
      .clk_sys(clk_sys), .rstn(rstn),
      .late_collision_reference_select(late_collision_reference_select),
      .evt_in(evt), .backoff_req(backoff_req), .abort_req(abort_req),
      .sts_data(sts_data), .sts_valid(sts_valid), .sts_ready(sts_ready),
      .sts_aborted(sts_aborted),
      .excessive_collision_flag(excessive_collision_flag),
      .late_collision_flag(late_collision_flag),
      .monitored_bad_flag(monitored_bad_flag), .stall(stall));

   // 100 MHz
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // pulse counters; sampled at the edge so a pulse counts exactly once
   always @(posedge clk_sys) begin
      if (backoff_req === 1'b1) n_backoff++;
      if (abort_req === 1'b1) n_abort++;
   end

   task automatic end_sim();
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   // ready only while valid, so exactly one word moves per call
   task automatic take_word(input logic [15:0] exp_d, input logic exp_a);
      int i;
      for (i = 0; i < 40 && sts_valid !== 1'b1; i++) @(negedge clk_sys);
      if (i == 40) begin
         n_fail++;
         $display("FAIL t=%0t no status word", $time);
         end_sim();
      end else begin
         `CHK(sts_data, exp_d)
         `CHK(sts_aborted, exp_a)
         sts_ready = 1'b1;
         @(negedge clk_sys);
         sts_ready = 1'b0;
      end
   endtask

   task automatic t_bad_crc();
      med.frame(1'b1);
      `CHK(monitored_bad_flag, 1'b1)
      take_word(16'h0008, 1'b0);
      med.frame(1'b0);
      take_word(16'h0000, 1'b0);
   endtask

   task automatic t_excess();
      n_backoff = 0;
      n_abort = 0;
      med.pulse(5);
      repeat (16) med.pulse(3);
      `CHK(n_backoff, 15)
      `CHK(n_abort, 1)
      `CHK(excessive_collision_flag, 1'b1)
      take_word(16'h0040, 1'b1);
   endtask

   task automatic t_late();
      n_backoff = 0;
      n_abort = 0;
      // window from first preamble bit
      med.pulse(5);
      idle(5200);
      med.pulse(3);
      `CHK(late_collision_flag, 1'b1)
      med.pulse(2);
      med.pulse(1);
      take_word(16'h0020, 1'b0);
      // window from delimiter: late from start, not yet from delimiter
      late_collision_reference_select = 1'b1;
      med.pulse(5);
      `CHK(late_collision_flag, 1'b0)
      idle(3000);
      med.pulse(4);
      idle(3000);
      med.pulse(3);
      `CHK(late_collision_flag, 1'b0)
      // a collision ends the window; the retry's delimiter opens a new one
      med.pulse(5);
      med.pulse(4);
      idle(5200);
      med.pulse(3);
      `CHK(late_collision_flag, 1'b1)
      med.pulse(2);
      med.pulse(1);
      take_word(16'h0020, 1'b0);
      med.frame(1'b0);
      take_word(16'h0000, 1'b0);
      `CHK(n_backoff, 3)
      `CHK(n_abort, 0)
   endtask

   // queue plus output register hold 17 words while the consumer stalls
   task automatic t_fifo();
      for (int i = 0; i < 17; i++) med.frame(i[0]);
      `CHK(stall, 1'b1)
      med.frame(1'b1);  // start refused while full
      for (int i = 0; i < 17; i++) begin
         take_word({12'h000, i[0], 3'h0}, 1'b0);
      end
      idle(10);
      `CHK(sts_valid, 1'b0)
      `CHK(stall, 1'b0)
   endtask

   // reset in mid-run drops the pending word and flags, then recovers
   task automatic t_reset();
      med.pulse(5);
      repeat (16) med.pulse(3);
      `CHK(excessive_collision_flag, 1'b1)
      rstn = 1'b0;
      idle(2);
      rstn = 1'b1;
      @(negedge clk_sys);
      `CHK({excessive_collision_flag, sts_valid, abort_req, stall}, 4'h0)
      med.frame(1'b1);
      take_word(16'h0008, 1'b0);
   endtask

   initial begin
      rstn = 1'b0;
      sts_ready = 1'b0;
      late_collision_reference_select = 1'b0;
      repeat (16) @(posedge clk_sys);
      @(negedge clk_sys);
      rstn = 1'b1;
      @(negedge clk_sys);
      `CHK({backoff_req, abort_req, sts_valid, stall}, 4'h0)
      t_bad_crc();
      t_excess();
      t_late();
      t_fifo();
      t_reset();
      end_sim();
   end

   // hang guard, far beyond the longest sequence
   initial begin
      #1000000;
      n_fail++;
      $display("FAIL t=%0t run limit reached", $time);
      end_sim();
   end
endmodule
`default_nettype wire
